// ---- dv/scp_config_port_properties.sv ----
// Checker on the serial configuration port top-level outputs, bound to the design.
`timescale 1ns/1ps
`default_nettype none
module scp_config_port_properties #(
    parameter int TUNE_W = 16
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              sync_pulse_ff,
    input wire logic              cal_start_ff,
    input wire logic              reference_lost,
    input wire logic [TUNE_W-1:0] loop_tune_code,
    input wire logic [TUNE_W-1:0] tune_hold_ff,
    input wire logic              tune_freeze_ff,
    input wire logic              cleaning_loop_on_ff,
    input wire logic              synthesis_loop_on_ff,
    input wire logic              synth_ref_osc_ff,
    input wire logic              dist_ref_b_ff,
    input wire logic [1:0]        ref_select_ff
);
    logic [1:0] up_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Settle count, since $past still sees reset values just after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_ff <= 2'h0;
        end else if (up_ff != 2'h3) begin
            up_ff <= up_ff + 2'h1;
        end
    end
    a_cal_one_pulse: assert property (cal_start_ff |=> !cal_start_ff)
        else $error("calibration start pulse too long");
    a_sync_one_pulse: assert property (sync_pulse_ff |=> !sync_pulse_ff)
        else $error("sync pulse too long");
    a_ref_sel_legal: assert property (ref_select_ff != 2'h3)
        else $error("reference select out of range");
    a_freeze_needs_loss: assert property (tune_freeze_ff |-> $past(reference_lost))
        else $error("tuning frozen without reference loss");
    a_freeze_holds_tune: assert property ((up_ff == 2'h3) && tune_freeze_ff
        && $past(tune_freeze_ff) |-> $stable(tune_hold_ff))
        else $error("tuning moved while frozen");
    a_tune_follows: assert property ((up_ff == 2'h3) && !tune_freeze_ff
        && !$past(tune_freeze_ff) |-> tune_hold_ff == $past(loop_tune_code))
        else $error("tuning not tracking input");
    a_dist_no_loops: assert property (dist_ref_b_ff
        |-> !cleaning_loop_on_ff && !synthesis_loop_on_ff)
        else $error("loop active in distribution mode");
    a_single_osc_ref: assert property (synth_ref_osc_ff
        |-> synthesis_loop_on_ff && !cleaning_loop_on_ff)
        else $error("single loop with cleaning loop on");
    a_clean_needs_synth: assert property (cleaning_loop_on_ff |-> synthesis_loop_on_ff)
        else $error("cleaning loop without synthesis loop");
    c_cal: cover property (cal_start_ff);
    c_sync: cover property (sync_pulse_ff);
    c_freeze: cover property (tune_freeze_ff);
    c_dist: cover property (dist_ref_b_ff);
endmodule : scp_config_port_properties
bind scp_config_port scp_config_port_properties #(.TUNE_W(TUNE_W)) chk_u (
    .pclk(pclk), .presetn(presetn), .sync_pulse_ff(sync_pulse_ff),
    .cal_start_ff(cal_start_ff), .reference_lost(reference_lost),
    .loop_tune_code(loop_tune_code), .tune_hold_ff(tune_hold_ff),
    .tune_freeze_ff(tune_freeze_ff), .cleaning_loop_on_ff(cleaning_loop_on_ff),
    .synthesis_loop_on_ff(synthesis_loop_on_ff), .synth_ref_osc_ff(synth_ref_osc_ff),
    .dist_ref_b_ff(dist_ref_b_ff), .ref_select_ff(ref_select_ff)
);
`default_nettype wire

// ---- dv/scp_host_model.sv ----
// Behavioural host that shifts configuration words into the serial port pins.
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
    input  wire logic pclk,
    output var  logic serial_clock_line,
    output var  logic serial_data_line,
    output var  logic latch_enable_line
);
    // Clock and latch rest low between frames
    initial begin
        serial_clock_line = 1'b0;
        serial_data_line  = 1'b0;
        latch_enable_line = 1'b0;
    end
    // One serial clock; high lasts two pclk and low at least three, so the port sees both edges
    task automatic tick(input logic d);
        @(posedge pclk);
        serial_data_line  <= d;
        repeat (2) @(posedge pclk);
        serial_clock_line <= 1'b1;
        repeat (2) @(posedge pclk);
        serial_clock_line <= 1'b0;
        serial_data_line  <= ~d; // No stale bit left on the idle line
    endtask : tick
    // Junk bits, then the word MSB first with latch low, then the latch pulse
    task automatic send_word(input logic [31:0] w, input int pre, input int hi);
        for (int i = 0; i < pre; i++) tick(i[0]);
        for (int i = 31; i >= 0; i--) tick(w[i]);
        @(posedge pclk);
        latch_enable_line <= 1'b1;
        repeat (2) @(posedge pclk);
        for (int i = 0; i < hi; i++) tick(1'b0); // Extra clocks, latch high
        @(posedge pclk);
        latch_enable_line <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : send_word
endmodule : scp_host_model
`default_nettype wire

// ---- dv/serial_config_port_mode_decode_tb.sv ----
// Bench: serial writes, mode decode, divide/delay staging, sync, readback, holdover.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module serial_config_port_mode_decode_tb;
    localparam int LIMIT = 20000;
    logic        pclk, presetn, psel, penable, pwrite, reference_lost, er;
    logic        pready_ff, pslverr_ff, readback_data_ff, sync_pulse_ff, cal_start_ff;
    logic        tune_freeze_ff, clean_ff, synth_ff, ext_ff, zd_ff, osc_ff, dist_ff;
    logic        sclk, sdat, lat;
    logic [1:0]  rsel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_ff, rd;
    logic [15:0] loop_tune_code, prev_code, tune_hold_ff, held;
    logic [65:0] div_w, dly_w;
    logic [26:0] wdat [4];
    logic [4:0]  modes [9] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B, 5'h10, 5'h01};
    int          err_count = 0, checks = 0, seed = 4, cyc = 0, sync_cnt = 0, cal_cnt = 0;

    scp_config_port dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .serial_clock_line(sclk), .serial_data_line(sdat), .latch_enable_line(lat),
        .readback_data_ff(readback_data_ff), .reference_lost(reference_lost),
        .loop_tune_code(loop_tune_code), .tune_hold_ff(tune_hold_ff),
        .tune_freeze_ff(tune_freeze_ff), .output_divide_value_ff(div_w),
        .output_digital_delay_ff(dly_w), .sync_pulse_ff(sync_pulse_ff),
        .cal_start_ff(cal_start_ff), .cleaning_loop_on_ff(clean_ff),
        .synthesis_loop_on_ff(synth_ff), .ext_vco_ff(ext_ff), .fb_from_output_ff(zd_ff),
        .fb_external_ff(), .synth_ref_osc_ff(osc_ff), .dist_ref_b_ff(dist_ff),
        .ref_select_ff(rsel));
    scp_host_model host_u (.pclk(pclk), .serial_clock_line(sclk),
        .serial_data_line(sdat), .latch_enable_line(lat));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Random tune codes, event counts and the hang guard
    always @(posedge pclk) begin
        loop_tune_code <= 16'($random(seed));
        prev_code      <= loop_tune_code;
        sync_cnt       <= sync_cnt + int'(sync_pulse_ff === 1'b1);
        cal_cnt        <= cal_cnt + int'(cal_start_ff === 1'b1);
        cyc            <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            tally_and_finish();
        end
    end
    // Expected flags {cleaning, synthesis, ext vco, zero delay, osc ref, distribution}
    function automatic logic [5:0] exp_mode(input logic [4:0] m);
        case (m)
            5'h00: exp_mode = 6'h30;
            5'h02: exp_mode = 6'h34;
            5'h03: exp_mode = 6'h38;
            5'h05: exp_mode = 6'h3C;
            5'h06: exp_mode = 6'h12;
            5'h08: exp_mode = 6'h16;
            5'h0B: exp_mode = 6'h1A;
            5'h10: exp_mode = 6'h01;
            default: exp_mode = 6'h00;
        endcase
    endfunction : exp_mode
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // One APB transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_ff !== 1'b1);
        rd = prdata_ff;
        er = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic word_rd(input logic [4:0] idx);
        apb(1'b1, `SCP_APB_INDEX, {27'h0, idx});
        apb(1'b0, `SCP_APB_DATA, 32'h0);
    endtask : word_rd
    task automatic tally_and_finish();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        {presetn, psel, penable, pwrite, reference_lost} = 5'h00;
        {paddr, pwdata, loop_tune_code, prev_code} = 76'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SCP_APB_STATUS, 32'h0);
        cmp(rd, 32'h00000100);
        apb(1'b0, 12'h010, 32'h0);
        cmp({rd[30:0], er}, 32'h1);
        $display("test map done");
        for (int i = 0; i < 4; i++) begin
            wdat[i] = 27'($random(seed));
            host_u.send_word({wdat[i], 5'(24 + i)}, (i == 0) ? 9 : 0, 0);
            word_rd(5'(24 + i));
            cmp(rd, {5'h0, wdat[i]});
        end
        $display("test words done");
        foreach (modes[i]) begin
            host_u.send_word({modes[i], 22'h0, `SCP_ADDR_MODE}, 0, 0);
            cmp({clean_ff, synth_ff, ext_ff, zd_ff, osc_ff, dist_ff}, exp_mode(modes[i]));
            apb(1'b0, `SCP_APB_STATUS, 32'h0);
            cmp(rd[8:3], {exp_mode(modes[i]) != 6'h00, modes[i]});
        end
        $display("test modes done");
        host_u.send_word({5'h0, 11'h000, 11'h019, 5'h02}, 0, 0);
        cmp(div_w[22+:11], 32'h19);
        host_u.send_word({5'h0, 11'h000, 11'h01A, 5'h02}, 0, 0);
        cmp(div_w[22+:11], 32'h19);
        repeat (2) host_u.tick(1'b0);
        cmp(div_w[22+:11], 32'h19);
        host_u.tick(1'b0);
        repeat (2) @(posedge pclk);
        cmp(div_w[22+:11], 32'h1A);
        $display("test divide done");
        host_u.send_word({5'h0, 11'h005, 11'h001, 5'h01}, 0, 0);
        cmp(dly_w[11+:11], 32'h0);
        apb(1'b1, `SCP_APB_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        cmp(dly_w[11+:11], 32'h5);
        host_u.send_word({5'h00, 18'h0, 1'b1, 3'h0, `SCP_ADDR_MODE}, 0, 0);
        host_u.send_word({5'h0, 11'h00D, 11'h001, 5'h03}, 0, 3);
        cmp(dly_w[33+:11], 32'hD);
        cmp(32'(sync_cnt), 32'h2);
        $display("test sync done");
        host_u.send_word({27'h0, `SCP_ADDR_CAL}, 0, 0);
        cmp(32'(cal_cnt), 32'h1);
        host_u.send_word({11'h000, 5'h18, 16'h001F}, 0, 0);
        for (int k = 26; k >= -1; k--) begin
            host_u.tick(1'b0);
            repeat (2) @(posedge pclk);
            cmp(readback_data_ff, (k >= 0) ? wdat[0][k] : 1'b0);
        end
        $display("test readback done");
        apb(1'b1, `SCP_APB_CTRL, 32'h2);
        reference_lost <= 1'b1;
        repeat (4) @(posedge pclk);
        held = tune_hold_ff;
        repeat (6) @(posedge pclk);
        cmp({tune_freeze_ff, tune_hold_ff}, {1'b1, held});
        reference_lost <= 1'b0;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        cmp({tune_freeze_ff, tune_hold_ff}, {1'b0, prev_code});
        $display("test holdover done");
        // Code 3 names no input and must fall back to input a
        for (int v = 2; v < 4; v++) begin
            host_u.send_word({25'h0, 2'(v), `SCP_ADDR_REFSEL}, 0, 0);
            cmp(rsel, (v == 3) ? 32'h0 : 32'(v));
        end
        $display("test refsel done");
        tally_and_finish();
    end
endmodule : serial_config_port_mode_decode_tb
`default_nettype wire

// ---- inc/scp_defines.svh ----
// Constants for the serial configuration port: word layout, field positions, counts, APB map.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

`define SCP_WORD_W        32
`define SCP_ADDR_W        5
`define SCP_DATA_W        27
`define SCP_DATA_LSB      5
`define SCP_NUM_REGS      32
`define SCP_NUM_OUT       6
`define SCP_CFG_RST       27'h0000000

// Channel word fields (word bit positions)
`define SCP_DIV_LSB       5
`define SCP_DIV_W         11
`define SCP_DDLY_LSB      16
`define SCP_DDLY_W        11
`define SCP_DIV_SMALL_MAX 25
`define SCP_DDLY_SMALL_MAX 12
`define SCP_EXTRA_CLKS    3

// Special word addresses
`define SCP_ADDR_FBSEL    5'h0A
`define SCP_ADDR_MODE     5'h0B
`define SCP_ADDR_REFSEL   5'h0D
`define SCP_ADDR_CAL      5'h1E
`define SCP_ADDR_RBSEL    5'h1F
`define SCP_MODE_LSB      27
`define SCP_AUTOSYNC_BIT  8
`define SCP_FBEXT_BIT     5
`define SCP_REFSEL_LSB    5
`define SCP_RBADDR_LSB    16
`define SCP_RB_BITS       27

// APB map
`define SCP_APB_CTRL      12'h000
`define SCP_APB_STATUS    12'h004
`define SCP_APB_INDEX     12'h008
`define SCP_APB_DATA      12'h00C
`define SCP_CTRL_SYNC_BIT 0
`define SCP_CTRL_HOLD_BIT 1
`define SCP_CTRL_RST      2'h0

`endif

// ---- inc/scp_pkg.sv ----
// Types shared by the serial configuration port files.
package scp_pkg;

    // Device operating modes
    typedef enum logic [4:0] {
        SCP_MODE_DUAL      = 5'h00,
        SCP_MODE_DUAL_ZD   = 5'h02,
        SCP_MODE_DUAL_EXT  = 5'h03,
        SCP_MODE_DUALZ_EXT = 5'h05,
        SCP_MODE_SINGLE    = 5'h06,
        SCP_MODE_SINGLE_ZD = 5'h08,
        SCP_MODE_SINGLE_EX = 5'h0B,
        SCP_MODE_DIST      = 5'h10
    } scp_mode_t;

    // Decoded mode flags
    typedef struct packed {
        logic valid;
        logic clean_on;
        logic synth_on;
        logic ext_vco;
        logic zero_dly;
        logic dist_only;
    } scp_mode_flags_t;

endpackage : scp_pkg

// ---- rtl/scp_config_port.sv ----
// Serial configuration port with channel divide/delay staging, sync, readback and APB status.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
module scp_config_port #(
    parameter int DIV_W  = `SCP_DIV_W,
    parameter int DDLY_W = `SCP_DDLY_W,
    parameter int NOUT   = `SCP_NUM_OUT,
    parameter int TUNE_W = 16
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata_ff,
    output logic                      pready_ff,
    output logic                      pslverr_ff,
    // Serial programming pins
    input  wire logic                 serial_clock_line,
    input  wire logic                 serial_data_line,
    input  wire logic                 latch_enable_line,
    output logic                      readback_data_ff,
    // Loop side
    input  wire logic                 reference_lost,
    input  wire logic [TUNE_W-1:0]    loop_tune_code,
    output logic      [TUNE_W-1:0]    tune_hold_ff,
    output logic                      tune_freeze_ff,
    output logic      [NOUT*DIV_W-1:0]  output_divide_value_ff,
    output logic      [NOUT*DDLY_W-1:0] output_digital_delay_ff,
    output logic                      sync_pulse_ff,
    output logic                      cal_start_ff,
    output logic                      cleaning_loop_on_ff,
    output logic                      synthesis_loop_on_ff,
    output logic                      ext_vco_ff,
    output logic                      fb_from_output_ff,
    output logic                      fb_external_ff,
    output logic                      synth_ref_osc_ff,
    output logic                      dist_ref_b_ff,
    output logic      [1:0]           ref_select_ff
);

    localparam int DL = `SCP_DATA_LSB;

    logic [`SCP_DATA_W-1:0] cfg_mem_ff [`SCP_NUM_REGS];
    logic [`SCP_WORD_W-1:0] shift_ff;
    logic                   sclk_q_ff;
    logic                   le_q_ff;
    logic [4:0]             last_addr_ff;
    logic [`SCP_DATA_W-1:0] rb_shift_ff;
    logic [4:0]             rb_cnt_ff;
    logic [1:0]             ctrl_ff;
    logic [4:0]             index_ff;
    logic                   soft_sync_ff;
    logic [NOUT-1:0]        pend_ff;
    logic                   sclk_rise;
    logic                   le_rise;
    logic                   le_fall;
    logic [4:0]             wr_addr;
    logic                   auto_sync;
    logic                   last_was_chan;
    logic                   sync_evt;
    logic                   apb_write;
    logic                   apb_first;
    logic                   apb_mapped;
    logic [31:0]            rd_word;
    logic [4:0]             rb_addr;
    scp_pkg::scp_mode_flags_t mode_flags;

    // Pins are synchronous to pclk, so a one-cycle history gives the edges
    assign sclk_rise = serial_clock_line & ~sclk_q_ff;
    assign le_rise   = latch_enable_line & ~le_q_ff;
    assign le_fall   = ~latch_enable_line & le_q_ff;
    assign wr_addr   = shift_ff[`SCP_ADDR_W-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q_ff <= 1'b0;
            le_q_ff   <= 1'b0;
        end else if (clk_en) begin
            sclk_q_ff <= serial_clock_line;
            le_q_ff   <= latch_enable_line;
        end
    end

    // Shift in while latch is low; older bits simply fall off the top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ff <= 32'h00000000;
        end else if (clk_en && sclk_rise && !latch_enable_line) begin
            shift_ff <= {shift_ff[`SCP_WORD_W-2:0], serial_data_line};
        end
    end

    // Latch rising edge moves the data field into the addressed word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < `SCP_NUM_REGS; k++) begin
                cfg_mem_ff[k] <= `SCP_CFG_RST;
            end
            last_addr_ff <= 5'h00;
        end else if (clk_en && le_rise) begin
            cfg_mem_ff[wr_addr] <= shift_ff[`SCP_WORD_W-1:DL];
            last_addr_ff        <= wr_addr;
        end
    end

    // Sync on latch fall after a channel write when auto-sync is on, or by software
    assign auto_sync     = cfg_mem_ff[`SCP_ADDR_MODE][`SCP_AUTOSYNC_BIT-DL];
    assign last_was_chan = (last_addr_ff < 5'(NOUT));
    assign sync_evt      = (le_fall && auto_sync && last_was_chan) || soft_sync_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_pulse_ff <= 1'b0;
        end else if (clk_en) begin
            sync_pulse_ff <= sync_evt;
        end
    end

    // Calibration starts on every write of the trigger word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_start_ff <= 1'b0;
        end else if (clk_en) begin
            cal_start_ff <= le_rise && (wr_addr == `SCP_ADDR_CAL);
        end
    end

    // Per-channel staging of divide and delay values
    for (genvar i = 0; i < NOUT; i++) begin : g_chan
        logic [DIV_W-1:0]  new_div;
        logic [DDLY_W-1:0] new_ddly;
        logic [DIV_W-1:0]  staged_div_ff;
        logic [DDLY_W-1:0] staged_ddly_ff;
        logic [DDLY_W-1:0] ready_ddly_ff;
        logic [1:0]        cnt_ff;
        logic              is_big;
        logic              load;

        assign new_div  = shift_ff[`SCP_DIV_LSB +: DIV_W];
        assign new_ddly = shift_ff[`SCP_DDLY_LSB +: DDLY_W];
        assign is_big   = (new_div > DIV_W'(`SCP_DIV_SMALL_MAX)) ||
                          (new_ddly > DDLY_W'(`SCP_DDLY_SMALL_MAX));
        assign load     = le_rise && (wr_addr == 5'(i));

        // Large values wait for three more serial clock rising edges; the edges
        // of a following word count too, which covers writing another register
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pend_ff[i]     <= 1'b0;
                cnt_ff         <= 2'h0;
                staged_div_ff  <= '0;
                staged_ddly_ff <= '0;
                ready_ddly_ff  <= '0;
                output_divide_value_ff[i*DIV_W +: DIV_W] <= '0;
            end else if (clk_en) begin
                if (load) begin
                    staged_div_ff  <= new_div;
                    staged_ddly_ff <= new_ddly;
                    cnt_ff         <= 2'h0;
                    pend_ff[i]     <= is_big;
                    if (!is_big) begin
                        output_divide_value_ff[i*DIV_W +: DIV_W] <= new_div;
                        ready_ddly_ff <= new_ddly;
                    end
                end else if (pend_ff[i] && sclk_rise) begin
                    if (cnt_ff == 2'(`SCP_EXTRA_CLKS - 1)) begin
                        pend_ff[i] <= 1'b0;
                        output_divide_value_ff[i*DIV_W +: DIV_W] <= staged_div_ff;
                        ready_ddly_ff <= staged_ddly_ff;
                    end else begin
                        cnt_ff <= cnt_ff + 2'h1;
                    end
                end
            end
        end

        // Delay reaches the output phase only at a sync event
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                output_digital_delay_ff[i*DDLY_W +: DDLY_W] <= '0;
            end else if (clk_en && sync_evt) begin
                output_digital_delay_ff[i*DDLY_W +: DDLY_W] <= ready_ddly_ff;
            end
        end
    end

    // Readback: load at latch fall, one bit per rising edge, zero once spent
    assign rb_addr = cfg_mem_ff[`SCP_ADDR_RBSEL][`SCP_RBADDR_LSB-DL +: 5];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_shift_ff      <= '0;
            rb_cnt_ff        <= 5'h00;
            readback_data_ff <= 1'b0;
        end else if (clk_en) begin
            if (le_fall) begin
                rb_shift_ff <= cfg_mem_ff[rb_addr];
                rb_cnt_ff   <= 5'(`SCP_RB_BITS);
            end else if (sclk_rise) begin
                if (rb_cnt_ff != 5'h00) begin
                    readback_data_ff <= rb_shift_ff[`SCP_DATA_W-1];
                    rb_shift_ff      <= {rb_shift_ff[`SCP_DATA_W-2:0], 1'b0};
                    rb_cnt_ff        <= rb_cnt_ff - 5'h01;
                end else begin
                    readback_data_ff <= 1'b0;
                end
            end
        end
    end

    // Mode decode and loop routing, registered so every output is a flop
    scp_mode_decode u_mode (
        .mode  (cfg_mem_ff[`SCP_ADDR_MODE][`SCP_MODE_LSB-DL +: 5]),
        .flags (mode_flags)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cleaning_loop_on_ff  <= 1'b0;
            synthesis_loop_on_ff <= 1'b0;
            ext_vco_ff           <= 1'b0;
            fb_from_output_ff    <= 1'b0;
            fb_external_ff       <= 1'b0;
            synth_ref_osc_ff     <= 1'b0;
            dist_ref_b_ff        <= 1'b0;
            ref_select_ff        <= 2'h0;
        end else if (clk_en) begin
            cleaning_loop_on_ff  <= mode_flags.clean_on;
            synthesis_loop_on_ff <= mode_flags.synth_on;
            ext_vco_ff           <= mode_flags.ext_vco;
            fb_from_output_ff    <= mode_flags.zero_dly;
            fb_external_ff       <= mode_flags.zero_dly &&
                                    cfg_mem_ff[`SCP_ADDR_FBSEL][`SCP_FBEXT_BIT-DL];
            synth_ref_osc_ff     <= mode_flags.synth_on && !mode_flags.clean_on;
            dist_ref_b_ff        <= mode_flags.dist_only;
            // Only inputs a, b, c exist; code 3 falls back to input a
            if (cfg_mem_ff[`SCP_ADDR_REFSEL][`SCP_REFSEL_LSB-DL +: 2] == 2'h3) begin
                ref_select_ff <= 2'h0;
            end else begin
                ref_select_ff <= cfg_mem_ff[`SCP_ADDR_REFSEL][`SCP_REFSEL_LSB-DL +: 2];
            end
        end
    end

    // With the cleaning loop on, holdover freezes tuning at the value it had when the reference went away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tune_freeze_ff <= 1'b0;
            tune_hold_ff   <= '0;
        end else if (clk_en) begin
            tune_freeze_ff <= ctrl_ff[`SCP_CTRL_HOLD_BIT] && mode_flags.clean_on &&
                              reference_lost;
            if (!(ctrl_ff[`SCP_CTRL_HOLD_BIT] && mode_flags.clean_on && reference_lost)) begin
                tune_hold_ff <= loop_tune_code;
            end
        end
    end

    // APB: one wait state, write commits at the edge where pready is seen high
    assign apb_first  = psel && penable && !pready_ff;
    assign apb_write  = psel && penable && pready_ff && pwrite && apb_mapped;
    assign apb_mapped = (paddr == `SCP_APB_CTRL) || (paddr == `SCP_APB_STATUS) ||
                        (paddr == `SCP_APB_INDEX) || (paddr == `SCP_APB_DATA);

    always_comb begin
        rd_word = 32'h00000000;
        unique case (paddr)
            `SCP_APB_CTRL:   rd_word = {30'h00000000, ctrl_ff};
            `SCP_APB_STATUS: rd_word = {10'h000, last_addr_ff, 2'h0, 6'(pend_ff),
                                        mode_flags.valid,
                                        cfg_mem_ff[`SCP_ADDR_MODE][`SCP_MODE_LSB-DL +: 5],
                                        tune_freeze_ff, cal_start_ff, sync_pulse_ff};
            `SCP_APB_INDEX:  rd_word = {27'h0000000, index_ff};
            `SCP_APB_DATA:   rd_word = {5'h00, cfg_mem_ff[index_ff]};
            default:         rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else if (clk_en) begin
            pready_ff  <= apb_first;
            pslverr_ff <= apb_first && !apb_mapped;
            if (apb_first) begin
                prdata_ff <= pwrite ? 32'h00000000 : rd_word;
            end
        end
    end

    // Control registers; the sync request bit self-clears after one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff      <= `SCP_CTRL_RST;
            index_ff     <= 5'h00;
            soft_sync_ff <= 1'b0;
        end else if (clk_en) begin
            soft_sync_ff <= apb_write && (paddr == `SCP_APB_CTRL) &&
                            pwdata[`SCP_CTRL_SYNC_BIT];
            if (apb_write && (paddr == `SCP_APB_CTRL)) begin
                ctrl_ff <= {pwdata[`SCP_CTRL_HOLD_BIT], 1'b0};
            end
            if (apb_write && (paddr == `SCP_APB_INDEX)) begin
                index_ff <= pwdata[4:0];
            end
        end
    end

endmodule : scp_config_port
`default_nettype wire

// ---- rtl/scp_mode_decode.sv ----
// Combinational decode of the device operating-mode field.
`timescale 1ns/1ps
`default_nettype none
module scp_mode_decode (
    input  wire logic [4:0]              mode,
    output var  scp_pkg::scp_mode_flags_t flags
);

    // Table decode; illegal codes leave every loop off and valid low
    always_comb begin
        flags = '0;
        unique case (mode)
            scp_pkg::SCP_MODE_DUAL:      flags = 6'b111000;
            scp_pkg::SCP_MODE_DUAL_ZD:   flags = 6'b111010;
            scp_pkg::SCP_MODE_DUAL_EXT:  flags = 6'b111100;
            scp_pkg::SCP_MODE_DUALZ_EXT: flags = 6'b111110;
            scp_pkg::SCP_MODE_SINGLE:    flags = 6'b101000;
            scp_pkg::SCP_MODE_SINGLE_ZD: flags = 6'b101010;
            scp_pkg::SCP_MODE_SINGLE_EX: flags = 6'b101100;
            scp_pkg::SCP_MODE_DIST:      flags = 6'b100001;
            default:                     flags = '0;
        endcase
    end

endmodule : scp_mode_decode
`default_nettype wire
